// ### exchange_xor_instruction_exec.sv
// Executor for the exchange, exchange-and-step and exclusive-OR instruction group.
`timescale 1ns/1ps
`default_nettype none
module exchange_xor_instruction_exec
    import exec_group_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              instr_valid,
    input  wire logic [7:0]        instr_byte,
    input  wire logic [7:0]        instr_operand,
    input  wire logic              basic_timer_interrupt,
    input  wire logic [7:0]        rom_data,
    input  wire logic              ram_load_valid,
    input  wire logic [ADDR_W-1:0] ram_load_addr,
    input  wire logic [3:0]        ram_load_data,
    input  wire logic              reg_load_valid,
    input  wire logic [2:0]        reg_load_index,
    input  wire logic [3:0]        reg_load_data,
    input  wire logic              carry_load,
    input  wire logic              carry_value,
    input  wire logic [ADDR_W-1:0] peek_addr,
    output logic                   ready,
    output logic                   done,
    output logic                   skip,
    output logic                   illegal,
    output logic                   pc_load,
    output logic      [13:0]       pc_target,
    output logic      [13:0]       rom_addr,
    output logic                   memory_bank_enable_flag,
    output logic                   register_bank_enable_flag,
    output logic                   carry_flag,
    output logic      [3:0]        accumulator,
    output logic      [3:0]        extended,
    output logic      [7:0]        pointer,
    output logic      [3:0]        peek_data
);
    localparam int DEPTH = 1 << ADDR_W;

    state_t            state;
    state_t            next_state;
    op_t               op;
    op_t               next_op;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [3:0]        regs      [0:7];
    logic [3:0]        next_regs [0:7];
    logic [3:0]        ram       [0:DEPTH-1];
    logic              next_ready;
    logic              next_done;
    logic              next_skip;
    logic              next_illegal;
    logic              next_pc_load;
    logic [13:0]       next_pc_target;
    logic [13:0]       next_rom_addr;
    logic              next_mem_flag;
    logic              next_reg_flag;
    logic              next_carry;
    logic [3:0]        next_peek;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [3:0]        mem_wd;
    logic [1:0]        pair_sel;
    logic [2:0]        pair_lo;
    logic [2:0]        pair_hi;
    logic [ADDR_W-1:0] ptr_addr;
    logic [ADDR_W-1:0] ind_addr;
    logic [ADDR_W-1:0] addr_next;
    logic [3:0]        step_val;
    logic              step_wrap;

    assign pair_sel    = (instr_byte == OPC_PREFIX_DC) ? instr_operand[2:1] : instr_byte[2:1];
    assign pair_lo     = {pair_sel, 1'b0};
    assign pair_hi     = {pair_sel, 1'b1};
    assign ptr_addr    = {regs[REG_H], regs[REG_L]};
    assign ind_addr    = {regs[pair_hi], regs[pair_lo]};
    assign addr_next   = addr + {{(ADDR_W-1){1'b0}}, 1'b1};
    assign accumulator = regs[REG_A];
    assign extended    = regs[REG_E];
    assign pointer     = ptr_addr;

    nibble_step u_step (
        .value  (regs[REG_L]),
        .down   (op == OP_DEC),
        .result (step_val),
        .wrap   (step_wrap)
    );

    always_comb begin
        next_state     = state;
        next_op        = op;
        next_addr      = addr;
        next_regs      = regs;
        next_ready     = ready;
        next_done      = 1'b0;
        next_skip      = 1'b0;
        next_illegal   = 1'b0;
        next_pc_load   = 1'b0;
        next_pc_target = pc_target;
        next_rom_addr  = rom_addr;
        next_mem_flag  = memory_bank_enable_flag;
        next_reg_flag  = register_bank_enable_flag;
        next_carry     = carry_flag;
        next_peek      = ram[peek_addr];
        mem_we         = 1'b0;
        mem_wa         = addr;
        mem_wd         = regs[REG_A];
        unique case (state)
            ST_VEC_HI: begin
                next_mem_flag         = rom_data[VEC_MEM_BIT];
                next_reg_flag         = rom_data[VEC_REG_BIT];
                next_pc_target[13:8]  = rom_data[5:0];
                next_rom_addr         = rom_addr + 14'h0001;
                next_state            = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                next_pc_target[7:0] = rom_data;
                next_pc_load        = 1'b1;
                next_ready          = 1'b1;
                next_state          = ST_IDLE;
            end
            ST_IDLE: begin
                if (basic_timer_interrupt) begin
                    next_rom_addr = VECTOR_TIMER;
                    next_ready    = 1'b0;
                    next_state    = ST_VEC_HI;
                end else if (instr_valid) begin
                    next_done = 1'b1;
                    next_op   = OP_NONE;
                    next_addr = instr_operand[ADDR_W-1:0];
                    if (instr_byte == OPC_SWAP_DIR || instr_byte == OPC_SWAP_WIDE) begin
                        next_regs[REG_A] = ram[instr_operand[ADDR_W-1:0]];
                        mem_we           = 1'b1;
                        mem_wa           = instr_operand[ADDR_W-1:0];
                        if (instr_byte == OPC_SWAP_WIDE) begin
                            next_op = OP_WIDE_DIR;
                        end
                        next_done  = 1'b0;
                        next_ready = 1'b0;
                        next_state = ST_EXEC2;
                    end else if (instr_byte == OPC_SWAP_INC || instr_byte == OPC_SWAP_DEC) begin
                        next_regs[REG_A] = ram[ptr_addr];
                        mem_we           = 1'b1;
                        mem_wa           = ptr_addr;
                        next_op    = (instr_byte == OPC_SWAP_DEC) ? OP_DEC : OP_INC;
                        next_done  = 1'b0;
                        next_ready = 1'b0;
                        next_state = ST_EXEC2;
                    end else if (instr_byte[7:3] == OPC_SWAP_REG) begin
                        next_regs[instr_byte[2:0]] = regs[REG_A];
                        next_regs[REG_A]           = regs[instr_byte[2:0]];
                    end else if (instr_byte[7:3] == OPC_SWAP_IND) begin
                        next_regs[REG_A] = ram[ind_addr];
                        mem_we           = 1'b1;
                        mem_wa           = ind_addr;
                    end else if (instr_byte == OPC_XOR_PTR) begin
                        next_regs[REG_A] = regs[REG_A] ^ ram[ptr_addr];
                    end else if (instr_byte == OPC_PREFIX_DD
                                 && instr_operand[7:4] == SUB_XOR_IMM) begin
                        next_regs[REG_A] = regs[REG_A] ^ instr_operand[3:0];
                        next_done  = 1'b0;
                        next_ready = 1'b0;
                        next_state = ST_EXEC2;
                    end else if (instr_byte == OPC_PREFIX_DC) begin
                        next_done  = 1'b0;
                        next_ready = 1'b0;
                        next_state = ST_EXEC2;
                        if (instr_operand == SUB_SWAP_PTR) begin
                            next_regs[REG_A] = ram[ptr_addr];
                            mem_we           = 1'b1;
                            mem_wa           = ptr_addr;
                            next_addr        = ptr_addr;
                            next_op          = OP_WIDE_PTR;
                        end else if (instr_operand[7:3] == SUB_SWAP_RR && !instr_operand[0]) begin
                            next_regs[pair_lo] = regs[REG_A];
                            next_regs[pair_hi] = regs[REG_E];
                            next_regs[REG_A]   = regs[pair_lo];
                            next_regs[REG_E]   = regs[pair_hi];
                        end else if (instr_operand[7:3] == SUB_XOR_ACC && !instr_operand[0]) begin
                            next_regs[REG_A] = regs[REG_A] ^ regs[pair_lo];
                            next_regs[REG_E] = regs[REG_E] ^ regs[pair_hi];
                        end else if (instr_operand[7:3] == SUB_XOR_PAIR && !instr_operand[0]) begin
                            next_regs[pair_lo] = regs[pair_lo] ^ regs[REG_A];
                            next_regs[pair_hi] = regs[pair_hi] ^ regs[REG_E];
                        end else begin
                            next_illegal = 1'b1;
                            next_done    = 1'b1;
                            next_ready   = 1'b1;
                            next_state   = ST_IDLE;
                        end
                    end else begin
                        next_illegal = 1'b1;
                    end
                end else begin
                    if (ram_load_valid) begin
                        mem_we = 1'b1;
                        mem_wa = ram_load_addr;
                        mem_wd = ram_load_data;
                    end
                    if (reg_load_valid) begin
                        next_regs[reg_load_index] = reg_load_data;
                    end
                    if (carry_load) begin
                        next_carry = carry_value;
                    end
                end
            end
            ST_EXEC2: begin
                next_done  = 1'b1;
                next_ready = 1'b1;
                next_state = ST_IDLE;
                unique case (op)
                    OP_WIDE_DIR, OP_WIDE_PTR: begin
                        next_regs[REG_E] = ram[addr_next];
                        mem_we           = 1'b1;
                        mem_wa           = addr_next;
                        mem_wd           = regs[REG_E];
                    end
                    OP_DEC, OP_INC: begin
                        next_regs[REG_L] = step_val;
                        if (step_wrap) begin
                            next_skip  = 1'b1;
                            next_done  = 1'b0;
                            next_ready = 1'b0;
                            next_state = ST_SKIP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            ST_SKIP: begin
                next_done  = 1'b1;
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state                     <= ST_VEC_HI;
            op                        <= OP_NONE;
            addr                      <= '0;
            ready                     <= 1'b0;
            done                      <= 1'b0;
            skip                      <= 1'b0;
            illegal                   <= 1'b0;
            pc_load                   <= 1'b0;
            pc_target                 <= 14'h0000;
            rom_addr                  <= VECTOR_RESET;
            memory_bank_enable_flag   <= 1'b0;
            register_bank_enable_flag <= 1'b0;
            carry_flag                <= 1'b0;
            peek_data                 <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                regs[i] <= 4'h0;
            end
            for (int j = 0; j < DEPTH; j++) begin
                ram[j] <= 4'h0;
            end
        end else begin
            state                     <= next_state;
            op                        <= next_op;
            addr                      <= next_addr;
            ready                     <= next_ready;
            done                      <= next_done;
            skip                      <= next_skip;
            illegal                   <= next_illegal;
            pc_load                   <= next_pc_load;
            pc_target                 <= next_pc_target;
            rom_addr                  <= next_rom_addr;
            memory_bank_enable_flag   <= next_mem_flag;
            register_bank_enable_flag <= next_reg_flag;
            carry_flag                <= next_carry;
            peek_data                 <= next_peek;
            regs                      <= next_regs;
            if (mem_we) begin
                ram[mem_wa] <= mem_wd;
            end
        end
    end

    a_reg_swap: assert property (@(posedge clock) disable iff (!resetn)
        ready && instr_valid && !basic_timer_interrupt && instr_byte[7:3] == OPC_SWAP_REG
        |=> done && accumulator == $past(regs[instr_byte[2:0]]))
        else $error("register exchange gave wrong accumulator or timing");
    a_direct_two_cycle: assert property (@(posedge clock) disable iff (!resetn)
        ready && instr_valid && !basic_timer_interrupt && instr_byte == OPC_SWAP_DIR
        |=> !ready && !done ##1 done && ready)
        else $error("direct exchange did not take two cycles");
    a_byte_direct: assert property (@(posedge clock) disable iff (!resetn)
        ready && instr_valid && !basic_timer_interrupt && instr_byte == OPC_SWAP_WIDE
        |=> ##1 done && extended == $past(ram[addr_next]))
        else $error("byte exchange upper nibble wrong");
    a_dec_skip: assert property (@(posedge clock) disable iff (!resetn)
        state == ST_EXEC2 && op == OP_DEC && regs[REG_L] == NIBBLE_RESET
        |=> skip && regs[REG_L] == NIBBLE_TOP ##1 done && ready)
        else $error("decrement wrap did not skip");
    a_inc_skip: assert property (@(posedge clock) disable iff (!resetn)
        state == ST_EXEC2 && op == OP_INC && regs[REG_L] == NIBBLE_TOP
        |=> skip && regs[REG_L] == NIBBLE_RESET ##1 done && ready)
        else $error("increment wrap did not skip");
    a_carry_kept: assert property (@(posedge clock) disable iff (!resetn)
        !ready |=> $stable(carry_flag))
        else $error("carry changed during execution");
    a_pointer_high: assert property (@(posedge clock) disable iff (!resetn)
        state == ST_EXEC2 && (op == OP_DEC || op == OP_INC)
        |=> regs[REG_H] == $past(regs[REG_H]))
        else $error("high pointer nibble changed");
    a_xor_memory: assert property (@(posedge clock) disable iff (!resetn)
        ready && instr_valid && !basic_timer_interrupt && instr_byte == OPC_XOR_PTR
        |=> done && accumulator == ($past(regs[REG_A]) ^ $past(ram[ptr_addr])))
        else $error("memory XOR result or timing wrong");
    a_xor_immediate: assert property (@(posedge clock) disable iff (!resetn)
        ready && instr_valid && !basic_timer_interrupt && instr_byte == OPC_PREFIX_DD
        && instr_operand[7:4] == SUB_XOR_IMM
        |=> !done ##1 done
        && accumulator == ($past(regs[REG_A], 2) ^ $past(instr_operand[3:0], 2)))
        else $error("immediate XOR result or timing wrong");
    a_vector_load: assert property (@(posedge clock) disable iff (!resetn)
        ready && basic_timer_interrupt |=> state == ST_VEC_HI && rom_addr == VECTOR_TIMER
        ##2 pc_load && ready)
        else $error("timer vector not taken from entry one");
endmodule : exchange_xor_instruction_exec
`default_nettype wire

// ### exchange_xor_instruction_exec_tb_top.sv
// Self-checking bench for the exchange and exclusive-OR instruction executor.
`timescale 1ns/1ps
`default_nettype none
module exchange_xor_instruction_exec_tb_top
    import exec_group_pkg::*;
;
    typedef struct {logic [3:0] a, e; logic [7:0] p; logic sk, il, c; int cy;} note_t;
    typedef struct {logic [13:0] pc; logic mf, rf;} vec_t;
    logic        clock = 0, resetn = 0, iv = 0, irq = 0, rml = 0, rgl = 0, cl = 0, sk_seen = 0;
    logic [7:0]  ib = 0, io = 0, la = 0, pa = 0, rom_data, ptr;
    logic [3:0]  ld_d = 0, acc, ext, peek;
    logic        ready, done, skip, illegal, pc_load, mflag, rflag, carry, mc;
    logic [13:0] pc_target, rom_addr;
    logic [3:0]  mr[8], mm[256];
    logic [7:0]  rom[4] = '{8'h81, 8'h23, 8'h42, 8'h5A};
    int          mismatches = 0, samples_checked = 0, cnt = 0;
    note_t       nq[$], n;
    vec_t        vq[$], v;
    assign rom_data = (rom_addr[13:2] == 12'h000) ? rom[rom_addr[1:0]] : 8'hA5;
    always #10 clock = ~clock;
    always @(posedge clock) cnt <= cnt + 1;
    exchange_xor_instruction_exec i_dut (
        .clock(clock), .resetn(resetn), .instr_valid(iv), .instr_byte(ib), .instr_operand(io),
        .basic_timer_interrupt(irq), .rom_data(rom_data), .ram_load_valid(rml),
        .ram_load_addr(la), .ram_load_data(ld_d), .reg_load_valid(rgl),
        .reg_load_index(la[2:0]), .reg_load_data(ld_d), .carry_load(cl), .carry_value(ld_d[0]),
        .peek_addr(pa), .ready(ready), .done(done), .skip(skip), .illegal(illegal),
        .pc_load(pc_load), .pc_target(pc_target), .rom_addr(rom_addr),
        .memory_bank_enable_flag(mflag), .register_bank_enable_flag(rflag),
        .carry_flag(carry), .accumulator(acc), .extended(ext), .pointer(ptr), .peek_data(peek));
    task automatic cmp_val(input string nm, input logic [13:0] e, g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic wait_rdy();
        for (int k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clock);
        if (ready !== 1'b1) cmp_val("ready", 14'h1, 14'h0);
    endtask : wait_rdy
    // Load strobes stay up until the next request lowers them, so no signal toggles twice.
    task automatic ld(input int k, input logic [7:0] a, input logic [3:0] d);
        iv = 0;
        rgl = (k == 0);
        rml = (k == 1);
        cl = (k == 2);
        la = a;
        ld_d = d;
        wait_rdy();
        if (k == 0) mr[a[2:0]] = d;
        else if (k == 1) mm[a] = d;
        else mc = d[0];
        @(negedge clock);
    endtask : ld
    task automatic sw(input logic [7:0] a, input int r);
        logic [3:0] t;
        t = mm[a];
        mm[a] = mr[r];
        mr[r] = t;
    endtask : sw
    task automatic model(input logic [7:0] b0, b1, output int lat, output logic sk, il);
        logic [7:0] ptr_m, acc_pair, pair_v;
        int p, q;
        lat = 2;
        sk = 0;
        il = 0;
        p = int'(b1[2:1]);
        q = int'(b0[2:1]);
        ptr_m = {mr[REG_H], mr[REG_L]};
        acc_pair = {mr[REG_E], mr[REG_A]};
        pair_v = {mr[2 * p + 1], mr[2 * p]};
        if (b0 == OPC_SWAP_INC || b0 == OPC_SWAP_DEC) begin
            sw(ptr_m, REG_A);
            mr[REG_L] = (b0 == OPC_SWAP_INC) ? mr[REG_L] + NIBBLE_ONE : mr[REG_L] - NIBBLE_ONE;
            sk = (mr[REG_L] == ((b0 == OPC_SWAP_INC) ? NIBBLE_RESET : NIBBLE_TOP));
            lat = sk ? 3 : 2;
        end else if (b0 == OPC_SWAP_DIR || b0 == OPC_SWAP_WIDE) begin
            sw(b1, REG_A);
            if (b0 == OPC_SWAP_WIDE) sw(b1 + 8'h01, REG_E);
        end else if (b0[7:3] == OPC_SWAP_REG) begin
            lat = 1;
            mr[REG_A] = mr[b0[2:0]];
            mr[b0[2:0]] = acc_pair[3:0];
        end else if (b0[7:3] == OPC_SWAP_IND) begin
            lat = 1;
            sw({mr[2 * q + 1], mr[2 * q]}, REG_A);
        end else if (b0 == OPC_XOR_PTR) begin
            lat = 1;
            mr[REG_A] = mr[REG_A] ^ mm[ptr_m];
        end else if (b0 == OPC_PREFIX_DD && b1[7:4] == SUB_XOR_IMM) begin
            mr[REG_A] = mr[REG_A] ^ b1[3:0];
        end else if (b0 == OPC_PREFIX_DC && b1 == SUB_SWAP_PTR) begin
            sw(ptr_m, REG_A);
            sw(ptr_m + 8'h01, REG_E);
        end else if (b0 == OPC_PREFIX_DC && b1[0] == 1'b0 && (b1[7:3] == SUB_SWAP_RR
                     || b1[7:3] == SUB_XOR_ACC || b1[7:3] == SUB_XOR_PAIR)) begin
            if (b1[7:3] != SUB_XOR_PAIR)
                {mr[REG_E], mr[REG_A]} = (b1[7:3] == SUB_SWAP_RR) ? pair_v : acc_pair ^ pair_v;
            if (b1[7:3] != SUB_XOR_ACC)
                {mr[2 * p + 1], mr[2 * p]} = (b1[7:3] == SUB_SWAP_RR) ? acc_pair
                                                                       : acc_pair ^ pair_v;
        end else begin
            lat = 1;
            il = 1;
        end
    endtask : model
    task automatic run(input logic [7:0] b0, b1);
        int lat;
        logic sk, il;
        rgl = 0;
        rml = 0;
        cl = 0;
        iv = 1;
        ib = b0;
        io = b1;
        wait_rdy();
        model(b0, b1, lat, sk, il);
        nq.push_back('{mr[REG_A], mr[REG_E], {mr[REG_H], mr[REG_L]}, sk, il, mc, cnt + lat});
        @(negedge clock);
    endtask : run
    task automatic test_end(input string nm);
        iv = 0;
        rgl = 0;
        rml = 0;
        cl = 0;
        for (int k = 0; k < 60 && nq.size() + vq.size() > 0; k++) @(negedge clock);
        if (nq.size() + vq.size() > 0) cmp_val("pending", 14'h0, 14'(nq.size() + vq.size()));
        $display("test %s finished", nm);
        @(negedge clock);
    endtask : test_end
    function automatic vec_t vec_of(input int k);
        return '{{rom[2 * k][5:0], rom[2 * k + 1]},
                 rom[2 * k][VEC_MEM_BIT], rom[2 * k][VEC_REG_BIT]};
    endfunction : vec_of
    task automatic do_reset();
        resetn = 0;
        mr = '{default: 4'h0};
        mm = '{default: 4'h0};
        mc = 0;
        repeat (12) @(negedge clock);
        vq.push_back(vec_of(0));
        resetn = 1;
    endtask : do_reset
    always @(negedge clock) begin
        if (resetn === 1'b1 && skip === 1'b1) sk_seen = 1'b1;
        if (resetn === 1'b1 && done === 1'b1) begin
            if (nq.size() == 0) cmp_val("spare_done", 14'h0, 14'h1);
            else begin
                n = nq.pop_front();
                cmp_val("accumulator", 14'(n.a), 14'(acc));
                cmp_val("extended", 14'(n.e), 14'(ext));
                cmp_val("pointer", 14'(n.p), 14'(ptr));
                cmp_val("skip", 14'(n.sk), 14'(sk_seen));
                cmp_val("illegal", 14'(n.il), 14'(illegal));
                cmp_val("carry", 14'(n.c), 14'(carry));
                cmp_val("done_cycle", 14'(n.cy), 14'(cnt));
            end
            sk_seen = 1'b0;
        end
        if (resetn === 1'b1 && pc_load === 1'b1) begin
            if (vq.size() == 0) cmp_val("spare_vector", 14'h0, 14'h1);
            else begin
                v = vq.pop_front();
                cmp_val("pc_target", v.pc, pc_target);
                cmp_val("mem_flag", 14'(v.mf), 14'(mflag));
                cmp_val("reg_flag", 14'(v.rf), 14'(rflag));
            end
        end
    end
    initial begin
        #400000;
        mismatches++;
        $display("watchdog expired");
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [7:0]  b0, b1;
        void'($urandom(3675));
        do_reset();
        test_end("reset_vector");
        ld(2, 8'h00, 4'h1);
        for (int i = 0; i < 8; i++) ld(0, 8'(i), 4'(3 * i + 1));
        ld(1, 8'hFF, 4'h9);
        ld(1, 8'h00, 4'h6);
        for (int i = 0; i < 8; i++) run({OPC_SWAP_REG, 3'(i)}, 8'h00);
        for (int i = 0; i < 8; i++) run({OPC_SWAP_IND, 3'(i)}, 8'hFF);
        run(OPC_SWAP_WIDE, 8'hFF);
        run(OPC_PREFIX_DC, SUB_SWAP_PTR);
        for (int i = 0; i < 4; i++) begin
            run(OPC_PREFIX_DC, {SUB_SWAP_RR, 2'(i), 1'b0});
            run(OPC_PREFIX_DC, {SUB_XOR_ACC, 2'(3 - i), 1'b0});
            run(OPC_PREFIX_DC, {SUB_XOR_PAIR, 2'(i), 1'b0});
            run(OPC_PREFIX_DD, {SUB_XOR_IMM, 4'(5 * i + 3)});
            run(OPC_XOR_PTR, 8'h00);
        end
        test_end("exchange_xor");
        ld(0, 8'(REG_L), NIBBLE_RESET);
        run(OPC_SWAP_DEC, 8'h00);
        run(OPC_SWAP_DEC, 8'h00);
        ld(0, 8'(REG_L), NIBBLE_TOP);
        run(OPC_SWAP_INC, 8'h00);
        run(OPC_SWAP_INC, 8'h00);
        run(OPC_PREFIX_DD, 8'h47);
        test_end("step_and_skip");
        wait_rdy();
        irq = 1;
        iv = 1;
        ib = {OPC_SWAP_REG, 3'h1};
        vq.push_back(vec_of(1));
        @(negedge clock);
        irq = 0;
        test_end("timer_vector");
        for (int i = 0; i < 120; i++) begin
            r = $urandom;
            b1 = r[15:8];
            case (r[2:0])
                3'h0: b0 = {OPC_SWAP_REG, r[5:3]};
                3'h1: b0 = {OPC_SWAP_IND, r[5:3]};
                3'h2: b0 = OPC_SWAP_WIDE;
                3'h3: b0 = OPC_XOR_PTR;
                3'h4: b1 = {SUB_XOR_IMM, r[11:8]};
                3'h5: b1 = {SUB_SWAP_RR, r[9:8], 1'b0};
                3'h6: b1 = {SUB_XOR_ACC, r[9:8], 1'b0};
                default: b1 = {SUB_XOR_PAIR, r[9:8], 1'b0};
            endcase
            if (r[2]) b0 = (r[2:0] == 3'h4) ? OPC_PREFIX_DD : OPC_PREFIX_DC;
            run(b0, b1);
            if (r[20]) ld(int'(r[22:21]) % 3, r[31:24], r[19:16]);
        end
        test_end("random");
        for (int i = 0; i < 256; i++) begin
            pa = 8'(i);
            repeat (2) @(negedge clock);
            cmp_val("peek", 14'(mm[i]), 14'(peek));
        end
        do_reset();
        test_end("second_reset");
        close_out();
    end
endmodule : exchange_xor_instruction_exec_tb_top
`default_nettype wire

// ### exec_group_pkg.sv
// Shared constants and the pointer nibble stepper for the exchange and XOR executor.
`timescale 1ns/1ps
`default_nettype none
package exec_group_pkg;
    localparam logic [7:0] OPC_SWAP_DIR   = 8'h79;
    localparam logic [7:0] OPC_SWAP_INC   = 8'h7A;
    localparam logic [7:0] OPC_SWAP_DEC   = 8'h7B;
    localparam logic [4:0] OPC_SWAP_REG   = 5'h0D;
    localparam logic [4:0] OPC_SWAP_IND   = 5'h0F;
    localparam logic [7:0] OPC_SWAP_WIDE  = 8'hCF;
    localparam logic [7:0] OPC_XOR_PTR    = 8'h3B;
    localparam logic [7:0] OPC_PREFIX_DD  = 8'hDD;
    localparam logic [7:0] OPC_PREFIX_DC  = 8'hDC;
    localparam logic [3:0] SUB_XOR_IMM    = 4'h3;
    localparam logic [7:0] SUB_SWAP_PTR   = 8'h01;
    localparam logic [4:0] SUB_SWAP_RR    = 5'h1C;
    localparam logic [4:0] SUB_XOR_ACC    = 5'h07;
    localparam logic [4:0] SUB_XOR_PAIR   = 5'h06;
    localparam int         REG_A          = 0;
    localparam int         REG_E          = 1;
    localparam int         REG_L          = 2;
    localparam int         REG_H          = 3;
    localparam logic [13:0] VECTOR_RESET  = 14'h0000;
    localparam logic [13:0] VECTOR_TIMER  = 14'h0002;
    localparam int         VEC_MEM_BIT    = 7;
    localparam int         VEC_REG_BIT    = 6;
    localparam logic [3:0] NIBBLE_RESET   = 4'h0;
    localparam logic [3:0] NIBBLE_TOP     = 4'hF;
    localparam logic [3:0] NIBBLE_ONE     = 4'h1;

    typedef enum logic [2:0] {
        ST_VEC_HI = 3'b000,
        ST_VEC_LO = 3'b001,
        ST_IDLE   = 3'b010,
        ST_EXEC2  = 3'b011,
        ST_SKIP   = 3'b100
    } state_t;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_WIDE_DIR = 3'b001,
        OP_WIDE_PTR = 3'b010,
        OP_DEC   = 3'b011,
        OP_INC   = 3'b100
    } op_t;
endpackage : exec_group_pkg

module nibble_step
    import exec_group_pkg::*;
(
    input  wire logic [3:0] value,
    input  wire logic       down,
    output logic      [3:0] result,
    output logic            wrap
);
    // The step stays inside the nibble; the borrow or carry that leaves it is reported only on wrap.
    always_comb begin
        result = down ? (value - NIBBLE_ONE) : (value + NIBBLE_ONE);
        wrap   = down ? (result == NIBBLE_TOP) : (result == NIBBLE_RESET);
    end
endmodule : nibble_step
`default_nettype wire
